// ==== core/cell_lookup.sv ====
`timescale 1ns/1ps
module cell_lookup
  import cell_pkg::*;
(
  input wire logic q, // feedback from own register
  input wire logic carry_in, // fast carry from lower cell
  input wire cell_ctrl_t ctrl, // shared synchronous controls
  input wire logic load_bit, // parallel load data
  output logic d, // next register value
  output logic carry_out // fast carry to upper cell
);

  logic [2:0] sel;
  logic sum;
  logic mux;

  // two lookup functions on the same three inputs
  always_comb
  begin
    sel = {ctrl.up, carry_in, q};
    sum = lut3(SUM_MASK, sel);
    carry_out = lut3(CARRY_MASK, sel);
  end

  // load selector, then clear gate, then clock-enable hold
  always_comb
  begin
    mux = ctrl.load_en ? load_bit : sum;
    if (ctrl.clearable)
    begin
      mux = mux & ~ctrl.sync_clr;
    end
    d = ctrl.clk_en ? mux : q;
  end

endmodule // cell_lookup

// ==== core/cell_pkg.sv ====
package cell_pkg;

  // register bus geometry
  localparam int unsigned APB_AW = 8;
  localparam int unsigned APB_DW = 32;
  localparam logic [APB_AW-1:0] OFS_CONFIG = 8'h00;
  localparam logic [APB_AW-1:0] OFS_COUNT = 8'h04;

  // config register field layout
  localparam int unsigned CFG_MODE_BIT = 0;
  localparam int unsigned CFG_ASYNC_LSB = 1;
  localparam int unsigned CFG_W = 3;

  // truth tables of the two lookup functions, indexed by {up, carry, q}
  localparam logic [7:0] SUM_MASK = 8'h66;
  localparam logic [7:0] CARRY_MASK = 8'h84;

  // reset value of a cell register
  localparam logic CELL_RESET = 1'b0;

  // how the two cluster control lines drive the asynchronous clear/preset
  typedef enum logic [1:0]
  {
    ASYNC_NONE = 2'b00,
    ASYNC_CLR_A = 2'b01,
    ASYNC_CLR_B = 2'b10,
    ASYNC_LOAD_A = 2'b11
  } async_sel_t;

  typedef enum logic
  {
    MODE_UPDOWN = 1'b0,
    MODE_CLEARABLE = 1'b1
  } count_mode_t;

  // packed so that async_sel sits at bits 2:1 and mode at bit 0
  typedef struct packed
  {
    async_sel_t async_sel;
    count_mode_t mode;
  } cell_cfg_t;

  localparam cell_cfg_t CFG_RESET = '{async_sel: ASYNC_NONE, mode: MODE_UPDOWN};

  // per-cell synchronous controls shared by every cell of the slice
  typedef struct packed
  {
    logic clk_en;
    logic up;
    logic clearable;
    logic sync_clr;
    logic load_en;
  } cell_ctrl_t;

  // one three-input lookup function
  function automatic logic lut3(input logic [7:0] mask, input logic [2:0] sel);
    return mask[sel];
  endfunction

endpackage

// ==== core/cell_register.sv ====
`timescale 1ns/1ps
module cell_register
  import cell_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic aclr, // async clear, active high
  input wire logic apre, // async preset, active high
  input wire logic d, // synchronous next value
  output logic q // register output
);

  // clear and preset only ever force constants; the data of an async
  // load reaches here already split into one of the two
  always_ff @(posedge pclk or negedge presetn or posedge aclr or posedge apre)
  begin
    if (!presetn)
    begin
      q <= CELL_RESET;
    end
    else if (aclr)
    begin
      q <= 1'b0;
    end
    else if (apre)
    begin
      q <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

endmodule // cell_register

// ==== core/logic_cell_counter_register.sv ====
`timescale 1ns/1ps
module logic_cell_counter_register
  import cell_pkg::*;
#(
  parameter int unsigned WIDTH = 8 // number of cells in the slice
)
(
  input wire logic pclk, // clock, 40 MHz
  input wire logic presetn, // async reset, active low
  input wire logic [APB_AW-1:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [APB_DW-1:0] pwdata, // apb write data
  output logic [APB_DW-1:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic clock_enable, // hold all cells when low
  input wire logic count_enable, // allow counting
  input wire logic up_down_in, // 1 counts up, 0 down; ignored in clearable mode
  input wire logic cascade_in, // count gate, or sync clear
  input wire logic load_en, // synchronous parallel load
  input wire logic [WIDTH-1:0] load_data, // parallel load data
  input wire logic carry_in, // carry into the lowest cell
  input wire logic cluster_control_line_a, // cluster control a
  input wire logic cluster_control_line_b, // cluster control b
  input wire logic [WIDTH-1:0] async_load_data_in, // async load data
  output logic [WIDTH-1:0] count_out, // cell register outputs
  output logic carry_out // fast carry out of top cell
);

  cell_cfg_t cfg_q;
  cell_ctrl_t ctrl;
  logic [WIDTH:0] carry;
  logic [WIDTH-1:0] next_bit;
  logic [WIDTH-1:0] aclr;
  logic [WIDTH-1:0] apre;
  logic clearable;
  logic line_clr;
  logic load_act;
  logic async_active;
  logic apb_setup;
  logic apb_access;
  logic [APB_DW-1:0] prdata_q;

  // address decode used by the error logic and the checks; write and read compare offsets directly
  function automatic logic is_mapped(input logic [APB_AW-1:0] a);
    return (a == OFS_CONFIG) || (a == OFS_COUNT);
  endfunction

  // read multiplexer, narrow fields sit in the low bits
  function automatic logic [APB_DW-1:0] read_word(
    input logic [APB_AW-1:0] a,
    input cell_cfg_t c,
    input logic [WIDTH-1:0] cnt
  );
    logic [APB_DW-1:0] w;
    w = '0;
    if (a == OFS_CONFIG)
    begin
      w[CFG_W-1:0] = c;
    end
    else if (a == OFS_COUNT)
    begin
      w[WIDTH-1:0] = cnt;
    end
    return w;
  endfunction

  // apb phases
  assign apb_setup = psel & ~penable;
  assign apb_access = psel & penable;

  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = apb_access & ~is_mapped(paddr);
  assign prdata = prdata_q;

  // config register: mode and async control routing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q <= CFG_RESET;
    end
    else if (apb_access && pwrite && paddr == OFS_CONFIG)
    begin
      cfg_q <= cell_cfg_t'(pwdata[CFG_W-1:0]);
    end
  end

  // read data is captured in the setup cycle so it stands in the access
  // cycle from a flop; a count change between the two is not reflected
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= '0;
    end
    else if (apb_setup && !pwrite)
    begin
      prdata_q <= read_word(paddr, cfg_q, count_out);
    end
  end

  // shared synchronous controls; in clearable mode the cascade input
  // becomes the synchronous clear and the direction is forced up
  assign clearable = (cfg_q.mode == MODE_CLEARABLE);
  always_comb
  begin
    ctrl.clk_en = clock_enable;
    ctrl.up = clearable ? 1'b1 : up_down_in;
    ctrl.clearable = clearable;
    ctrl.sync_clr = clearable & cascade_in;
    ctrl.load_en = load_en;
  end

  // carry into the lowest cell carries the count enable; the cascade
  // input only gates counting while it is not a clear
  assign carry[0] = carry_in & count_enable & (clearable | cascade_in);
  assign carry_out = carry[WIDTH];

  // async routing; load data is split into a clear or a preset per
  // cell, so no lookup function is spent on it
  assign line_clr = ((cfg_q.async_sel == ASYNC_CLR_A) & cluster_control_line_a)
                  | ((cfg_q.async_sel == ASYNC_CLR_B) & cluster_control_line_b);
  assign load_act = (cfg_q.async_sel == ASYNC_LOAD_A) & cluster_control_line_a;
  assign aclr = {WIDTH{line_clr}} | ({WIDTH{load_act}} & ~async_load_data_in);
  assign apre = {WIDTH{load_act}} & async_load_data_in;
  assign async_active = line_clr | load_act;

  // one lookup pair and one register per cell, chained by fast carry
  generate
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_cell
      cell_lookup u_lookup
      (
        .q(count_out[i]),
        .carry_in(carry[i]),
        .ctrl(ctrl),
        .load_bit(load_data[i]),
        .d(next_bit[i]),
        .carry_out(carry[i+1])
      );
      cell_register u_reg
      (
        .pclk(pclk),
        .presetn(presetn),
        .aclr(aclr[i]),
        .apre(apre[i]),
        .d(next_bit[i]),
        .q(count_out[i])
      );
    end
  endgenerate

  // checks below share one clock and the bus reset
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // counting up by one when every gate is open
  chk_count_up: assert property (
    (!async_active && clock_enable && !load_en && carry[0] && ctrl.up && !ctrl.sync_clr)
    |=> (async_active || count_out == WIDTH'($past(count_out) + 1'b1)))
  else $error("count up step wrong");

  // counting down by one in up/down mode
  chk_count_down: assert property (
    (!async_active && clock_enable && !load_en && carry[0] && !clearable && !up_down_in)
    |=> (async_active || count_out == WIDTH'($past(count_out) - 1'b1)))
  else $error("count down step wrong");

  // fast carry ripples only across a run of ones when counting up
  chk_carry_chain: assert property (
    (carry[0] && ctrl.up && (&count_out)) |-> carry_out)
  else $error("carry out missing on full count");

  // synchronous load takes the load data on the next edge
  chk_sync_load: assert property (
    (!async_active && clock_enable && load_en && !ctrl.sync_clr)
    |=> (async_active || count_out == $past(load_data)))
  else $error("synchronous load lost");

  // clearable mode: clear beats load and count
  chk_sync_clear: assert property (
    (!async_active && clock_enable && clearable && cascade_in)
    |=> (async_active || count_out == '0))
  else $error("synchronous clear not applied");

  // clearable mode ignores the direction input
  chk_no_direction: assert property (
    (!async_active && clock_enable && !load_en && carry[0] && clearable && !cascade_in
     && !up_down_in)
    |=> (async_active || count_out == WIDTH'($past(count_out) + 1'b1)))
  else $error("clearable mode counted down");

  // in up/down mode the cascade input only gates counting
  chk_cascade_gate: assert property (
    (!async_active && clock_enable && !load_en && !clearable && !cascade_in)
    |=> (async_active || $stable(count_out)))
  else $error("cascade gate did not hold count");

  // clock enable low holds every cell
  chk_clk_hold: assert property (
    (!async_active && !clock_enable) |=> (async_active || $stable(count_out)))
  else $error("clock enable did not hold");

  // line a as async clear forces zero throughout its assertion
  chk_async_clr_a: assert property (
    (cfg_q.async_sel == ASYNC_CLR_A && cluster_control_line_a) |-> count_out == '0)
  else $error("line a async clear failed");

  // line b as async clear, also against a pending load
  chk_async_clr_b: assert property (
    (cfg_q.async_sel == ASYNC_CLR_B && cluster_control_line_b && load_en)
    |-> count_out == '0)
  else $error("line b async clear failed");

  // async load shows the load data while line a is high
  chk_async_load: assert property (
    (cfg_q.async_sel == ASYNC_LOAD_A && cluster_control_line_a)
    |-> count_out == async_load_data_in)
  else $error("async load value wrong");

  // after an async load is released the value is kept by the register
  chk_async_keep: assert property (
    (cfg_q.async_sel == ASYNC_LOAD_A && cluster_control_line_a && !clock_enable)
    ##1 (!async_active && !clock_enable)
    |-> count_out == $past(async_load_data_in))
  else $error("async load not retained");

  // unmapped accesses flag an error, mapped ones do not
  chk_bus_error: assert property (
    apb_access |-> (pslverr == !is_mapped(paddr)))
  else $error("bus error decode wrong");

  // a config write is in the config register after the next edge
  chk_cfg_write: assert property (
    (apb_access && pwrite && paddr == OFS_CONFIG)
    |=> (cfg_q == cell_cfg_t'($past(pwdata[CFG_W-1:0]))))
  else $error("config write not stored");

  // count enable low stops the count but leaves load and clear alone
  chk_count_gate_en: assert property (
    (!async_active && clock_enable && !load_en && !ctrl.sync_clr && !count_enable)
    |=> (async_active || $stable(count_out)))
  else $error("count enable did not hold count");

  // the incoming carry gates counting like the count enable does
  chk_carry_in_gate: assert property (
    (!async_active && clock_enable && !load_en && !ctrl.sync_clr && !carry_in)
    |=> (async_active || $stable(count_out)))
  else $error("carry in low did not hold count");

  // clock enable low also blocks a pending synchronous load
  chk_load_no_ce: assert property (
    (!async_active && !clock_enable && load_en)
    |=> (async_active || $stable(count_out)))
  else $error("load taken with clock enable low");

  // clock enable low also blocks the synchronous clear
  chk_clear_no_ce: assert property (
    (!async_active && !clock_enable && clearable && cascade_in)
    |=> (async_active || $stable(count_out)))
  else $error("clear taken with clock enable low");

  // in up/down mode a high cascade input never clears the count
  chk_cascade_no_clr: assert property (
    (!async_active && clock_enable && !clearable && cascade_in && !load_en && !carry[0])
    |=> (async_active || $stable(count_out)))
  else $error("cascade input cleared in up/down mode");

  // borrow ripples across a run of zeros when counting down
  chk_carry_down: assert property (
    (carry[0] && !ctrl.up && count_out == '0) |-> carry_out)
  else $error("borrow out missing on zero count");

  // no carry enters the chain, so none may leave it
  chk_carry_block: assert property (
    !carry[0] |-> !carry_out)
  else $error("carry out without carry in");

  // a lowest bit that stops the ripple stops the whole chain
  chk_carry_break: assert property (
    ((ctrl.up && !count_out[0]) || (!ctrl.up && count_out[0]))
    |-> !carry_out)
  else $error("carry passed a breaking bit");

  // line b as async clear forces zero while it is high
  chk_async_clr_b_line: assert property (
    (cfg_q.async_sel == ASYNC_CLR_B && cluster_control_line_b)
    |-> count_out == '0)
  else $error("line b async clear failed");

  // with no async routing both lines leave the register alone
  chk_async_none: assert property (
    (cfg_q.async_sel == ASYNC_NONE && (cluster_control_line_a || cluster_control_line_b)
     && !clock_enable) |=> (async_active || $stable(count_out)))
  else $error("unrouted async line changed count");

  // in async load routing only line a acts, line b is ignored
  chk_line_b_unused: assert property (
    (cfg_q.async_sel == ASYNC_LOAD_A && cluster_control_line_b && !cluster_control_line_a
     && !clock_enable) |=> (async_active || $stable(count_out)))
  else $error("line b acted in async load routing");

  // a config read returns the config seen at its setup edge
  chk_rd_config: assert property (
    (apb_setup && !pwrite && paddr == OFS_CONFIG)
    |=> (prdata[CFG_W-1:0] == $past(cfg_q) && prdata[APB_DW-1:CFG_W] == '0))
  else $error("config read data wrong");

  // a count read returns the count seen at its setup edge
  chk_rd_count: assert property (
    (apb_setup && !pwrite && paddr == OFS_COUNT)
    |=> (prdata[WIDTH-1:0] == $past(count_out) && prdata[APB_DW-1:WIDTH] == '0))
  else $error("count read data wrong");

  // unmapped reads return zero
  chk_rd_unmapped: assert property (
    (apb_setup && !pwrite && !is_mapped(paddr)) |=> prdata == '0)
  else $error("unmapped read not zero");

  // read data only moves at a read setup edge
  chk_rd_stands: assert property (
    !(apb_setup && !pwrite) |=> $stable(prdata))
  else $error("read data changed outside a read");

  // config only changes through a config write
  chk_cfg_hold: assert property (
    !(apb_access && pwrite && paddr == OFS_CONFIG)
    |=> $stable(cfg_q))
  else $error("config changed without a write");

  // the error response only stands in an access phase
  chk_err_idle: assert property (!apb_access |-> !pslverr)
  else $error("bus error outside access");

endmodule // logic_cell_counter_register

// ==== tb/cell_user_logic.sv ====
`timescale 1ns/1ps
module cell_user_logic
(
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic [23:0] cmd, // requested cell controls
  output logic [23:0] drv // registered controls to the cell
);
  // user logic launches its controls from flops on the shared clock,
  // so nothing reaches the cell between edges except async lines held level
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      drv <= '0;
    else
      drv <= cmd;
endmodule // cell_user_logic

// ==== tb/tb_logic_cell_counter_register.sv ====
`timescale 1ns/1ps
module tb_logic_cell_counter_register;
  import cell_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_DW-1:0] pwdata = '0;
  logic [APB_DW-1:0] prdata;
  logic pready;
  logic pslverr;
  logic [23:0] cmd = '0;
  logic [23:0] drv;
  logic [7:0] count_out;
  logic carry_out;
  logic [7:0] exp_fifo[$];
  logic [7:0] cnt_e = 8'h00;
  cell_cfg_t cfg_e = CFG_RESET;
  logic [31:0] seed = 32'hfed6;
  int err_count = 0;
  int tests_run = 0;

  // drv layout: line a, line b, ce, count en, up, cascade, load, carry, load data, async data
  cell_user_logic u_cell_user_logic (.pclk(pclk), .presetn(presetn), .cmd(cmd), .drv(drv));
  logic_cell_counter_register #(.WIDTH(8)) u_logic_cell_counter_register (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clock_enable(drv[21]), .count_enable(drv[20]), .up_down_in(drv[19]),
    .cascade_in(drv[18]), .load_en(drv[17]), .load_data(drv[15:8]), .carry_in(drv[16]),
    .cluster_control_line_a(drv[23]), .cluster_control_line_b(drv[22]),
    .async_load_data_in(drv[7:0]), .count_out(count_out), .carry_out(carry_out));

  // free-running clock
  initial
    forever #12.5 pclk = ~pclk;

  task automatic complete_run();
    if (err_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    tests_run++;
    if (got !== e)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, e);
    end
  endtask

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  // clocked next value; priority hold > sync clear > load > count
  function automatic logic [7:0] nxt(input logic [7:0] c, input logic [23:0] v);
    if (!v[21])
      return c;
    if (cfg_e.mode == MODE_CLEARABLE && v[18])
      return 8'h00;
    if (v[17])
      return v[15:8];
    if (v[16] && v[20] && (cfg_e.mode == MODE_CLEARABLE || v[18]))
      return (cfg_e.mode == MODE_CLEARABLE || v[19]) ? c + 8'h01 : c - 8'h01;
    return c;
  endfunction

  // bit 8 says an async control is live, low bits give the forced value
  function automatic logic [8:0] asy(input logic [23:0] v);
    case (cfg_e.async_sel)
      ASYNC_CLR_A: return {v[23], 8'h00};
      ASYNC_CLR_B: return {v[22], 8'h00};
      ASYNC_LOAD_A: return {v[23], v[7:0]};
      default: return 9'h000;
    endcase
  endfunction

  // async lines are kept rare so the clocked paths get most of the traffic
  function automatic logic [23:0] rnd_cmd();
    logic [31:0] r;
    seed = xorshift(seed);
    r = seed;
    return {&r[31:29], &r[28:26], |r[25:24], |r[23:22], r[21],
      ((cfg_e.mode == MODE_CLEARABLE) ? &r[20:18] : |r[20:19]), &r[17:16], |r[15:14],
      r[7:0] ^ r[13:6], r[31:24]};
  endfunction

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rd_v, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait as long as the slave stretches the access; only the watchdog ends it
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd_v = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
    logic [31:0] r;
    logic er;
    apb(1'b0, a, 32'h0, r, er);
    chk(r, e);
    chk({31'h0, er}, {31'h0, ee});
  endtask

  // one cell update: the command acts for exactly one edge, then clock enable drops
  task automatic step(input logic [23:0] v);
    logic [8:0] a;
    logic [7:0] c;
    logic cl;
    logic cy;
    @(posedge pclk);
    cmd <= v;
    @(posedge pclk);
    cmd <= v & ~24'h200000;
    a = asy(v);
    @(negedge pclk);
    if (a[8])
      chk({24'h0, count_out}, {24'h0, a[7:0]});
    // fast carry under the controls of v, on the value before the update edge
    c = a[8] ? a[7:0] : cnt_e;
    cl = (cfg_e.mode == MODE_CLEARABLE);
    cy = v[16] & v[20] & (cl | v[18]) & ((cl | v[19]) ? &c : ~|c);
    chk({31'h0, carry_out}, {31'h0, cy});
    cnt_e = a[8] ? a[7:0] : nxt(cnt_e, v);
    @(posedge pclk);
    exp_fifo.push_back(cnt_e);
  endtask

  // monitor: every noted value is compared once the update edge has settled
  always @(negedge pclk)
    if (exp_fifo.size() > 0)
      chk({24'h0, count_out}, {24'h0, exp_fifo.pop_front()});

  // watchdog: the whole sequence needs well under 2000 cycles
  initial
  begin
    #400000;
    err_count++;
    complete_run();
  end

  initial
  begin
    logic [31:0] r;
    logic e;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_CONFIG, 32'h0, 1'b0);
    rd(OFS_COUNT, 32'h0, 1'b0);
    rd(8'h08, 32'h0, 1'b1);
    apb(1'b1, OFS_COUNT, 32'hff, r, e);
    rd(OFS_COUNT, 32'h0, 1'b0);
    // wrap boundaries: load ff then up, load 00 then down
    step(24'h22ff00);
    step(24'h3d0000);
    step(24'h220000);
    step(24'h350000);
    for (int m = 0; m < 8; m++)
    begin
      step(24'h000000);
      cfg_e = cell_cfg_t'(m[2:0]);
      apb(1'b1, OFS_CONFIG, {29'h0, cfg_e} | 32'hf0, r, e);
      rd(OFS_CONFIG, {29'h0, cfg_e}, 1'b0);
      repeat (40) step(rnd_cmd());
      rd(OFS_COUNT, {24'h0, cnt_e}, 1'b0);
    end
    // second reset in mid-run
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    cnt_e = 8'h00;
    cfg_e = CFG_RESET;
    rd(OFS_CONFIG, 32'h0, 1'b0);
    rd(OFS_COUNT, 32'h0, 1'b0);
    step(24'h3d0000);
    repeat (2) @(posedge pclk);
    complete_run();
  end
endmodule // tb_logic_cell_counter_register
